// ===== include/smc_params.svh
// Behaviour
// - monitor mode: off, log, log plus shutdown
// - level above limit triggers chosen action
// - monitor readback: mode, limit, last level
// - ping timeout in ms, zero disables
// - ping command only refreshes the watchdog
// - ping timeout defaults from nonvolatile data
// - three 16-bit duties, LSB first, 1024 full
// - duties default from nonvolatile data
// - duty readback in write byte layout
// - transition frames equal eight times byte
// - de-gamma index applied and read back
// - 63 measurement slots, refreshed each frame
// - start 0..62, count 1..63, sum within 63
// - first reply byte is frame counter
// - three bytes per slot, value then status
// - values arrive scaled per channel
// - status bit 4 marks unassigned slot
// - error codes parity, saturate, underflow, timing
// - error codes for previous-measurement faults
// - slot to channel mapping from configuration
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_OP_APL_WR 8'h2f
`define SMC_OP_APL_RD 8'h30
`define SMC_OP_PING_WR 8'h33
`define SMC_OP_PING_RD 8'h34
`define SMC_OP_PING 8'h46
`define SMC_OP_PWM_WR 8'h47
`define SMC_OP_PWM_RD 8'h48
`define SMC_OP_RATE_WR 8'h49
`define SMC_OP_RATE_RD 8'h4a
`define SMC_OP_DEGAMMA_WR 8'h54
`define SMC_OP_DEGAMMA_RD 8'h55
`define SMC_OP_MEAS_RD 8'h5c
`define SMC_ADDR_CMD 2'h0
`define SMC_ADDR_DATA 2'h1
`define SMC_MODE_OFF 8'h00
`define SMC_MODE_LOG 8'h01
`define SMC_MODE_SHUT 8'h02
`define SMC_NUM_SLOTS 63
`define SMC_MAX_START 8'h3e
`define SMC_MAX_COUNT 8'h3f
`define SMC_SLOT_LIMIT 9'h03f
`define SMC_STATUS_UNUSED 5'h10
`define SMC_PWM_FULL 16'h0400
`define SMC_CLK_MHZ 250
`define SMC_PING_UNIT_US 1000
`define SMC_MS_CYCLES (`SMC_PING_UNIT_US * `SMC_CLK_MHZ)
`endif

// ===== include/smc_pkg.sv
package smc_pkg;
  typedef logic [7:0] smc_byte_type;
  typedef enum logic [1:0] {SMC_IDLE, SMC_COLLECT, SMC_REPLY} smc_state_type;
  typedef struct packed {
    logic [4:0] status;
    logic [15:0] value;
  } smc_meas_type;
endpackage

// ===== include/smc_ctl_if.sv
`timescale 1ns/1ns
interface smc_ctl_if;
  logic ce;
  logic [2:0][15:0] duty;
  logic [7:0] timeout;
  logic kick;
  logic lost;
  modport ctl (output ce, duty, timeout, kick, input lost);
  modport pwm (input ce, duty);
  modport wdg (input ce, timeout, kick, output lost);
endinterface

// ===== core/smc_ping_watchdog.sv
`timescale 1ns/1ns
`include "smc_params.svh"
module smc_ping_watchdog #(
  parameter int MS_CYCLES = `SMC_MS_CYCLES
) (
  input wire logic i_clk,    // system clock
  input wire logic i_rst_b,  // async reset, active low
  smc_ctl_if.wdg ctl         // timeout, kick and lost flag
);
  localparam int PW = $clog2(MS_CYCLES);
  logic [PW-1:0] pre_r;
  logic [7:0] elapsed_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_r <= '0;
      elapsed_r <= 8'h00;
    end else if (ctl.ce) begin
      if (ctl.kick) begin
        pre_r <= '0;
        elapsed_r <= 8'h00;
      end else if (pre_r == PW'(MS_CYCLES - 1)) begin
        pre_r <= '0;
        if (elapsed_r != 8'hff) begin
          elapsed_r <= elapsed_r + 8'h01;
        end
      end else begin
        pre_r <= pre_r + PW'(1);
      end
    end
  end

  // lost stays set until the host talks again; a zero timeout disarms it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl.lost <= 1'b0;
    end else if (ctl.ce) begin
      if (ctl.kick || ctl.timeout == 8'h00) begin
        ctl.lost <= 1'b0;
      end else if (elapsed_r >= ctl.timeout) begin
        ctl.lost <= 1'b1;
      end
    end
  end

  AST_PING_KICK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ctl.ce && ctl.kick) |=> !ctl.lost) else $error("lost flag set right after a command");
  AST_PING_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ctl.ce && ctl.timeout == 8'h00) |=> !ctl.lost) else $error("lost flag with watchdog disabled");
endmodule

// ===== core/smc_pwm_gen.sv
`timescale 1ns/1ns
`include "smc_params.svh"
module smc_pwm_gen #(
  parameter int CHANNELS = 3
) (
  input wire logic i_clk,                 // system clock
  input wire logic i_rst_b,               // async reset, active low
  smc_ctl_if.pwm ctl,                     // duty values
  output logic [CHANNELS-1:0] o_pwm       // pwm outputs
);
  // 1024-step period, so a duty of 1024 or more holds the output high
  logic [9:0] phase_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_r <= 10'h000;
    end else if (ctl.ce) begin
      phase_r <= phase_r + 10'h001;
    end
  end

  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        o_pwm[g] <= 1'b0;
      end else if (ctl.ce) begin
        o_pwm[g] <= {6'h00, phase_r} < ctl.duty[g];
      end
    end
    AST_PWM_FULL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (ctl.ce && ctl.duty[g] >= `SMC_PWM_FULL) |=> o_pwm[g]) else $error("full duty not high");
    AST_PWM_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (ctl.ce && ctl.duty[g] == 16'h0000) |=> !o_pwm[g]) else $error("zero duty not low");
  end
endmodule

// ===== core/smc_command_handler.sv
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "smc_params.svh"
module smc_command_handler #(
  parameter int MS_CYCLES = `SMC_MS_CYCLES
) (
  input wire logic i_clk,                          // system clock, 250 MHz
  input wire logic i_rst_b,                        // async reset, active low
  input wire logic i_ce,                           // clock enable, freezes all state
  input wire logic [1:0] i_addr,                   // 0 opcode/status, 1 param/reply
  input wire smc_pkg::smc_byte_type i_wdata,       // write byte
  input wire logic i_wr,                           // write strobe
  input wire logic i_rd,                           // read strobe
  output smc_pkg::smc_byte_type o_rdata,           // read byte, cycle after strobe
  input wire smc_pkg::smc_byte_type i_nv_ping_timeout, // nonvolatile ping timeout
  input wire logic [47:0] i_nv_pwm_duty,           // nonvolatile duties, ch0 low
  input wire logic i_apl_valid,                    // new picture level this frame
  input wire smc_pkg::smc_byte_type i_apl_level,   // measured picture level
  output logic o_apl_error,                        // one-cycle level error pulse
  output logic o_apl_shutdown,                     // emergency shutdown level
  input wire logic i_frame_tick,                   // frame boundary pulse
  input wire logic i_meas_we,                      // measurement slot update
  input wire logic [5:0] i_meas_slot,              // slot being updated
  input wire logic [15:0] i_meas_value,            // scaled two's complement value
  input wire logic [4:0] i_meas_status,            // unused flag and error code
  output logic [2:0] o_pwm,                        // pwm outputs
  output logic o_ping_lost,                        // host ping timeout flag
  output logic [10:0] o_bin_transition_frames,     // frames per bin transition
  output smc_pkg::smc_byte_type o_degamma_index,   // selected de-gamma curve
  output logic o_cmd_error                         // sticky command error
);
  import smc_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  smc_state_type state_r, state_nxt;
  smc_byte_type op_r;
  logic [3:0] need_r;
  logic [2:0] pcnt_r;
  smc_byte_type pbuf_r [0:5];
  smc_byte_type prm [0:5];
  smc_byte_type apl_mode_r, apl_limit_r, apl_level_r;
  smc_byte_type ping_to_r, rate_r, frame_cnt_r;
  logic [2:0][15:0] duty_r;
  logic boot_r;
  smc_meas_type meas_r [0:`SMC_NUM_SLOTS-1];
  smc_byte_type rsp_r [0:5];
  smc_byte_type rsp_nxt [0:5];
  logic [7:0] rsp_len_r, rsp_len_nxt, rsp_idx_r;
  logic rsp_meas_r;
  logic [5:0] slot_r;
  logic [1:0] part_r;
  smc_byte_type rsp_byte;
  logic cmd_wr, data_wr, stray_wr, rsp_rd, stat_rd;
  logic exec, bad, ok_exec, is_read, unknown;
  smc_byte_type exec_op;
  logic [3:0] need_cmd;

  smc_ctl_if ctl ();

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] smc_param_len(input smc_byte_type op);
    case (op)
      `SMC_OP_APL_WR: smc_param_len = 4'h2;
      `SMC_OP_PING_WR, `SMC_OP_RATE_WR, `SMC_OP_DEGAMMA_WR: smc_param_len = 4'h1;
      `SMC_OP_PWM_WR: smc_param_len = 4'h6;
      `SMC_OP_MEAS_RD: smc_param_len = 4'h2;
      `SMC_OP_APL_RD, `SMC_OP_PING_RD, `SMC_OP_PING, `SMC_OP_PWM_RD,
      `SMC_OP_RATE_RD, `SMC_OP_DEGAMMA_RD: smc_param_len = 4'h0;
      default: smc_param_len = 4'hf;
    endcase
  endfunction

  assign cmd_wr = i_ce && i_wr && i_addr == `SMC_ADDR_CMD;
  assign data_wr = i_ce && i_wr && i_addr == `SMC_ADDR_DATA && state_r == SMC_COLLECT;
  assign stray_wr = i_ce && i_wr && i_addr == `SMC_ADDR_DATA && state_r != SMC_COLLECT;
  assign rsp_rd = i_ce && i_rd && i_addr == `SMC_ADDR_DATA && state_r == SMC_REPLY;
  assign stat_rd = i_ce && i_rd && i_addr == `SMC_ADDR_CMD;
  assign need_cmd = smc_param_len(i_wdata);
  assign unknown = cmd_wr && need_cmd == 4'hf;
  assign exec_op = cmd_wr ? i_wdata : op_r;
  assign exec = (cmd_wr && need_cmd == 4'h0) || (data_wr && 4'(pcnt_r) + 4'h1 == need_r);

  always_comb begin
    for (int k = 0; k < 6; k++) begin
      prm[k] = pbuf_r[k];
    end
    if (data_wr) begin
      prm[pcnt_r] = i_wdata;
    end
  end

  always_comb begin
    bad = 1'b0;
    case (exec_op)
      `SMC_OP_APL_WR: bad = prm[0] > `SMC_MODE_SHUT;
      `SMC_OP_MEAS_RD: bad = prm[0] > `SMC_MAX_START || prm[1] == 8'h00 || prm[1] > `SMC_MAX_COUNT ||
        ({1'b0, prm[0]} + {1'b0, prm[1]}) > `SMC_SLOT_LIMIT;
      default: bad = 1'b0;
    endcase
  end

  assign ok_exec = exec && !bad;
  assign is_read = exec_op == `SMC_OP_APL_RD || exec_op == `SMC_OP_PING_RD || exec_op == `SMC_OP_PWM_RD ||
    exec_op == `SMC_OP_RATE_RD || exec_op == `SMC_OP_DEGAMMA_RD || exec_op == `SMC_OP_MEAS_RD;

  always_comb begin
    state_nxt = state_r;
    if (cmd_wr) begin
      state_nxt = (need_cmd == 4'h0 || unknown) ? SMC_IDLE : SMC_COLLECT;
    end
    if (ok_exec && is_read) begin
      state_nxt = SMC_REPLY;
    end else if (exec) begin
      state_nxt = SMC_IDLE;
    end
    if (rsp_rd && rsp_idx_r + 8'h01 == rsp_len_r) begin
      state_nxt = SMC_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= SMC_IDLE;
      op_r <= 8'h00;
      need_r <= 4'h0;
      pcnt_r <= 3'h0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      if (cmd_wr) begin
        op_r <= i_wdata;
        need_r <= need_cmd;
        pcnt_r <= 3'h0;
      end else if (data_wr) begin
        pcnt_r <= pcnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < 6; k++) begin
        pbuf_r[k] <= 8'h00;
      end
    end else if (data_wr) begin
      pbuf_r[pcnt_r] <= i_wdata;
    end
  end

  // set wins over the clear done by a status read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cmd_error <= 1'b0;
    end else if (i_ce) begin
      if ((exec && bad) || unknown || stray_wr) begin
        o_cmd_error <= 1'b1;
      end else if (stat_rd) begin
        o_cmd_error <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  // defaults are taken one edge after reset release, never under reset itself
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_r <= 1'b1;
      ping_to_r <= 8'h00;
      duty_r <= '0;
    end else if (i_ce) begin
      boot_r <= 1'b0;
      if (boot_r) begin
        ping_to_r <= i_nv_ping_timeout;
        duty_r <= i_nv_pwm_duty;
      end else if (ok_exec && exec_op == `SMC_OP_PING_WR) begin
        ping_to_r <= prm[0];
      end else if (ok_exec && exec_op == `SMC_OP_PWM_WR) begin
        for (int c = 0; c < 3; c++) begin
          duty_r[c] <= {prm[2*c+1], prm[2*c]};
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      apl_mode_r <= `SMC_MODE_OFF;
      apl_limit_r <= 8'h00;
      rate_r <= 8'h00;
      o_degamma_index <= 8'h00;
    end else if (ok_exec) begin
      case (exec_op)
        `SMC_OP_APL_WR: begin
          apl_mode_r <= prm[0];
          apl_limit_r <= prm[1];
        end
        `SMC_OP_RATE_WR: rate_r <= prm[0];
        `SMC_OP_DEGAMMA_WR: o_degamma_index <= prm[0];
        default: ;
      endcase
    end
  end

  // zero gives an immediate change, 0xff the longest ramp of 2040 frames
  assign o_bin_transition_frames = {rate_r, 3'b000};

  // ----------------------------------------------------------------
  // picture level monitor
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      apl_level_r <= 8'h00;
      o_apl_error <= 1'b0;
      o_apl_shutdown <= 1'b0;
    end else if (i_ce) begin
      o_apl_error <= 1'b0;
      if (ok_exec && exec_op == `SMC_OP_APL_WR) begin
        o_apl_shutdown <= 1'b0;
      end
      if (i_apl_valid) begin
        apl_level_r <= i_apl_level;
        if (apl_mode_r != `SMC_MODE_OFF && i_apl_level > apl_limit_r) begin
          o_apl_error <= 1'b1;
          if (apl_mode_r == `SMC_MODE_SHUT) begin
            o_apl_shutdown <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // measurement slots
  // ----------------------------------------------------------------
  // values come scaled per channel and indexed by configured slot, so
  // this store keeps no channel knowledge of its own
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int s = 0; s < `SMC_NUM_SLOTS; s++) begin
        meas_r[s] <= '{status: `SMC_STATUS_UNUSED, value: 16'h0000};
      end
    end else if (i_ce && i_meas_we && i_meas_slot < 6'(`SMC_NUM_SLOTS)) begin
      meas_r[i_meas_slot] <= '{status: i_meas_status, value: i_meas_value};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frame_cnt_r <= 8'h00;
    end else if (i_ce && i_frame_tick) begin
      frame_cnt_r <= frame_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // reply
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      rsp_nxt[k] = 8'h00;
    end
    rsp_len_nxt = 8'h01;
    case (exec_op)
      `SMC_OP_APL_RD: begin
        rsp_nxt[0] = apl_mode_r;
        rsp_nxt[1] = apl_limit_r;
        rsp_nxt[2] = apl_level_r;
        rsp_len_nxt = 8'h03;
      end
      `SMC_OP_PING_RD: rsp_nxt[0] = ping_to_r;
      `SMC_OP_PWM_RD: begin
        for (int c = 0; c < 3; c++) begin
          rsp_nxt[2*c] = duty_r[c][7:0];
          rsp_nxt[2*c+1] = duty_r[c][15:8];
        end
        rsp_len_nxt = 8'h06;
      end
      `SMC_OP_RATE_RD: rsp_nxt[0] = rate_r;
      `SMC_OP_DEGAMMA_RD: rsp_nxt[0] = o_degamma_index;
      `SMC_OP_MEAS_RD: begin
        rsp_nxt[0] = frame_cnt_r;
        rsp_len_nxt = 8'h01 + 8'(prm[1] * 2'd3);
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < 6; k++) begin
        rsp_r[k] <= 8'h00;
      end
      rsp_len_r <= 8'h00;
      rsp_meas_r <= 1'b0;
    end else if (ok_exec && is_read) begin
      for (int k = 0; k < 6; k++) begin
        rsp_r[k] <= rsp_nxt[k];
      end
      rsp_len_r <= rsp_len_nxt;
      rsp_meas_r <= exec_op == `SMC_OP_MEAS_RD;
    end
  end

  // slot values are read live, so a long block read may span a frame update
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rsp_idx_r <= 8'h00;
      slot_r <= 6'h00;
      part_r <= 2'h0;
    end else if (ok_exec && is_read) begin
      rsp_idx_r <= 8'h00;
      slot_r <= prm[0][5:0];
      part_r <= 2'h0;
    end else if (rsp_rd) begin
      rsp_idx_r <= rsp_idx_r + 8'h01;
      if (rsp_meas_r && rsp_idx_r != 8'h00) begin
        if (part_r == 2'h2) begin
          part_r <= 2'h0;
          slot_r <= slot_r + 6'h01;
        end else begin
          part_r <= part_r + 2'h1;
        end
      end
    end
  end

  always_comb begin
    rsp_byte = rsp_r[rsp_idx_r[2:0]];
    if (rsp_meas_r && rsp_idx_r != 8'h00) begin
      case (part_r)
        2'h0: rsp_byte = meas_r[slot_r].value[7:0];
        2'h1: rsp_byte = meas_r[slot_r].value[15:8];
        default: rsp_byte = {3'b000, meas_r[slot_r].status};
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (rsp_rd) begin
        o_rdata <= rsp_byte;
      end else if (stat_rd) begin
        o_rdata <= {6'h00, state_r == SMC_REPLY, o_cmd_error};
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // outer blocks
  // ----------------------------------------------------------------
  assign ctl.ce = i_ce;
  assign ctl.duty = duty_r;
  assign ctl.timeout = ping_to_r;
  assign ctl.kick = cmd_wr;
  assign o_ping_lost = ctl.lost;

  smc_ping_watchdog #(.MS_CYCLES(MS_CYCLES)) u_wdg (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .ctl(ctl.wdg)
  );

  smc_pwm_gen #(.CHANNELS(3)) u_pwm (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .ctl(ctl.pwm),
    .o_pwm(o_pwm)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  AST_APL_SHUT: assert property (
    (i_ce && i_apl_valid && apl_mode_r == `SMC_MODE_SHUT && i_apl_level > apl_limit_r)
      |=> o_apl_shutdown && o_apl_error) else $error("shutdown missing on level over limit");
  AST_APL_OFF: assert property (
    (i_ce && i_apl_valid && (apl_mode_r == `SMC_MODE_OFF || i_apl_level <= apl_limit_r))
      |=> !o_apl_error) else $error("level error without cause");
  AST_MODE_BAD: assert property (
    (exec && exec_op == `SMC_OP_APL_WR && prm[0] > `SMC_MODE_SHUT)
      |=> o_cmd_error && apl_mode_r == $past(apl_mode_r)) else $error("bad mode accepted");
  AST_START_BAD: assert property (
    (exec && exec_op == `SMC_OP_MEAS_RD && prm[0] > `SMC_MAX_START)
      |=> state_r != SMC_REPLY ##1 !rsp_rd) else $error("bad start index answered");
  AST_BOOT_LOAD: assert property (
    $fell(boot_r) |-> ping_to_r == $past(i_nv_ping_timeout)) else $error("ping default not loaded");
  AST_BOOT_PWM: assert property (
    $fell(boot_r) |-> duty_r == $past(i_nv_pwm_duty)) else $error("pwm default not loaded");
  AST_FRAME_FIRST: assert property (
    (rsp_rd && rsp_meas_r && rsp_idx_r == 8'h00) |=> o_rdata == $past(rsp_r[0]))
    else $error("first reply byte is not frame count");

  COV_APL_SHUT: cover property (i_ce && i_apl_valid && apl_mode_r == `SMC_MODE_SHUT && i_apl_level > apl_limit_r);
  COV_MEAS_READ: cover property (rsp_rd && rsp_meas_r && rsp_idx_r + 8'h01 == rsp_len_r);
  COV_PING_LOST: cover property ($rose(o_ping_lost));
endmodule

// ===== testbench/smc_far_model.sv
`timescale 1ns/1ns
module smc_far_model (
  input wire logic i_clk,           // system clock
  output logic o_apl_valid,         // level strobe
  output logic [7:0] o_apl_level,   // picture level
  output logic o_frame_tick,        // frame pulse
  output logic o_meas_we,           // slot write strobe
  output logic [5:0] o_meas_slot,   // mapped slot
  output logic [15:0] o_meas_value, // scaled value
  output logic [4:0] o_meas_status  // flag and code
);
  initial begin
    o_apl_valid = 1'b0;
    o_apl_level = 8'h00;
    o_frame_tick = 1'b0;
    o_meas_we = 1'b0;
    o_meas_slot = 6'h00;
    o_meas_value = 16'h0000;
    o_meas_status = 5'h00;
  end
  task automatic level(input logic [7:0] l);
    @(posedge i_clk);
    o_apl_valid <= 1'b1;
    o_apl_level <= l;
    @(posedge i_clk);
    o_apl_valid <= 1'b0;
    o_apl_level <= ~l;
  endtask
  task automatic tick;
    @(posedge i_clk);
    o_frame_tick <= 1'b1;
    @(posedge i_clk);
    o_frame_tick <= 1'b0;
  endtask
  // slot index arrives already mapped from its channel, value already scaled
  task automatic slot(input logic [5:0] s, input logic [15:0] v, input logic [4:0] st);
    @(posedge i_clk);
    o_meas_we <= 1'b1;
    o_meas_slot <= s;
    o_meas_value <= v;
    o_meas_status <= st;
    @(posedge i_clk);
    o_meas_we <= 1'b0;
    o_meas_value <= ~v; // idle bus must not echo the last value
  endtask
endmodule

// ===== testbench/smc_command_handler_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module smc_command_handler_tb;
  import smc_pkg::*;
  typedef struct {logic [7:0] op; int n; logic [47:0] p;} smc_row_type;
  // write rows; each read opcode is the write opcode plus one
  smc_row_type rows [4] = '{'{8'h33, 1, 48'h05}, '{8'h47, 6, 48'h0123_0400_0000}, '{8'h49, 1, 48'hff},
    '{8'h54, 1, 48'h03}};
  logic [15:0] bad [4] = '{16'h023e, 16'h013f, 16'h0000, 16'h4000};
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_ce = 1'b1;
  logic [7:0] nv_to = 8'h07;
  logic [47:0] nv_duty = 48'h0003_0400_0100;
  logic i_apl_valid, i_frame_tick, i_meas_we;
  logic [7:0] i_apl_level;
  logic [5:0] i_meas_slot;
  logic [15:0] i_meas_value;
  logic [4:0] i_meas_status;
  smc_byte_type o_rdata, o_degamma_index;
  logic o_apl_error, o_apl_shutdown, o_ping_lost, o_cmd_error;
  logic [2:0] o_pwm;
  logic [10:0] o_bin_transition_frames;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  smc_command_handler #(.MS_CYCLES(8)) smc_command_handler_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_nv_ping_timeout(nv_to), .i_nv_pwm_duty(nv_duty), .i_apl_valid(i_apl_valid),
    .i_apl_level(i_apl_level), .o_apl_error(o_apl_error), .o_apl_shutdown(o_apl_shutdown),
    .i_frame_tick(i_frame_tick), .i_meas_we(i_meas_we), .i_meas_slot(i_meas_slot), .i_meas_value(i_meas_value),
    .i_meas_status(i_meas_status), .o_pwm(o_pwm), .o_ping_lost(o_ping_lost),
    .o_bin_transition_frames(o_bin_transition_frames), .o_degamma_index(o_degamma_index),
    .o_cmd_error(o_cmd_error));
  smc_far_model far_i (.i_clk(i_clk), .o_apl_valid(i_apl_valid), .o_apl_level(i_apl_level),
    .o_frame_tick(i_frame_tick), .o_meas_we(i_meas_we), .o_meas_slot(i_meas_slot),
    .o_meas_value(i_meas_value), .o_meas_status(i_meas_status));
  // ----------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // host bus tasks
  // ----------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask
  task automatic cmd(input logic [7:0] op, input int n, input logic [47:0] p);
    wr(2'h0, op);
    for (int i = 0; i < n; i++) wr(2'h1, p[8*i+:8]);
  endtask
  task automatic rdn(input int n, input logic [47:0] e);
    for (int i = 0; i < n; i++) rd(2'h1, e[8*i+:8]);
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    nap(2);
    cmd(8'h34, 0, '0);
    rd(2'h1, 8'h07);
    cmd(8'h48, 0, '0);
    rdn(6, 48'h0003_0400_0100);
    `CHK(o_pwm[1], 1'b1)
    foreach (rows[k]) begin
      cmd(rows[k].op, rows[k].n, rows[k].p);
      cmd(rows[k].op + 8'h01, 0, '0);
      rdn(rows[k].n, rows[k].p);
    end
    `CHK(o_bin_transition_frames, 11'h7f8)
    `CHK(o_pwm[1:0], 2'b10)
    `CHK(o_degamma_index, 8'h03)
    for (int m = 0; m < 3; m++) begin
      cmd(8'h2f, 2, {40'h0, 8'h40, m[7:0]});
      far_i.level(8'h41);
      #1;
      `CHK(o_apl_error, m != 0)
      nap(1);
      `CHK(o_apl_shutdown, m == 2)
    end
    far_i.level(8'h40);
    #1;
    `CHK(o_apl_error, 1'b0)
    cmd(8'h30, 0, '0);
    rdn(3, 48'h40_40_02);
    cmd(8'h2f, 2, 48'h00_03);
    nap(1);
    `CHK(o_cmd_error, 1'b1)
    rd(2'h0, 8'h01);
    cmd(8'h30, 0, '0);
    rdn(2, 48'h40_02);
    far_i.slot(6'h02, 16'hfedc, 5'h07);
    repeat (3) far_i.tick();
    cmd(8'h5c, 2, 48'h02_02);
    rdn(6, 48'h0000_07fe_dc03);
    rd(2'h1, 8'h10);
    cmd(8'h5c, 2, 48'h01_3e);
    rdn(4, 48'h1000_0003);
    foreach (bad[k]) begin
      cmd(8'h5c, 2, {32'h0, bad[k]});
      nap(1);
      rd(2'h0, 8'h01);
    end
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    cmd(8'h33, 1, 48'h02);
    nap(30);
    `CHK(o_ping_lost, 1'b1)
    cmd(8'h46, 0, '0);
    nap(1);
    `CHK(o_ping_lost, 1'b0)
    cmd(8'h33, 1, 48'h00);
    nap(40);
    `CHK(o_ping_lost, 1'b0)
    cmd(8'h49, 1, 48'h00);
    nap(2);
    `CHK(o_bin_transition_frames, 11'h000)
    // a write while the clock enable is low must leave the setting alone
    @(posedge i_clk);
    i_ce <= 1'b0;
    cmd(8'h49, 1, 48'h11);
    @(posedge i_clk);
    i_ce <= 1'b1;
    nap(2);
    `CHK(o_bin_transition_frames, 11'h000)
    `CHK(o_apl_shutdown, 1'b1)
    // mid-run reset with new nonvolatile defaults
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    nv_to <= 8'h09;
    nv_duty <= 48'h0000_0000_0200;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    nap(2);
    `CHK(o_apl_shutdown, 1'b0)
    cmd(8'h34, 0, '0);
    rd(2'h1, 8'h09);
    cmd(8'h48, 0, '0);
    rdn(6, 48'h0000_0000_0200);
    final_report();
  end
endmodule
